// *** rtl/vgat_timing.sv ***
// Raster timing generator with pixel fetch and two-entry pixel buffer
module vgat_timing
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Video memory request
  output vgat_pkg::vgat_fetch_t o_fetch,
  // Pixel data from video memory
  input wire logic i_pix_valid,
  input wire vgat_pkg::vgat_colour_t i_pix_data,
  output logic o_pix_ready,
  // Monitor side
  output logic o_hsync_n,
  output logic o_vsync_n,
  output vgat_pkg::vgat_colour_t o_colour,
  output vgat_pkg::vgat_pos_t o_pos
);

  // Raster counter state
  logic [1:0] div;
  logic [9:0] hcnt;
  logic [9:0] vcnt;
  logic [1:0] next_div;
  logic [9:0] next_hcnt;
  logic [9:0] next_vcnt;
  logic tick;
  logic [9:0] ahead_col;
  logic [9:0] ahead_row;
  logic next_visible;

  // Pixel buffer state
  vgat_pkg::vgat_colour_t slot [2];
  logic wr_idx;
  logic rd_idx;
  logic [1:0] fill;
  vgat_pkg::vgat_colour_t next_slot [2];
  logic next_wr_idx;
  logic next_rd_idx;
  logic [1:0] next_fill;
  logic push;
  logic pop;

  // Output state
  vgat_pkg::vgat_fetch_t next_fetch;
  logic next_pix_ready;
  logic next_hsync_n;
  logic next_vsync_n;
  vgat_pkg::vgat_colour_t next_colour;

  // Counter next values
  always_comb
  begin
    tick = (div == vgat_pkg::DIV_LAST);
    next_div = tick ? 2'h0 : div + 2'h1;
    next_hcnt = hcnt;
    next_vcnt = vcnt;
    if (tick)
    begin
      if (hcnt == vgat_pkg::H_LAST)
      begin
        next_hcnt = 10'h000;
        next_vcnt = (vcnt == vgat_pkg::V_LAST) ? 10'h000 : vcnt + 10'h001;
      end
      else
      begin
        next_hcnt = hcnt + 10'h001;
      end
    end
    // Position one pixel beyond the next, requested ahead of display
    if (next_hcnt == vgat_pkg::H_LAST)
    begin
      ahead_col = 10'h000;
      ahead_row = (next_vcnt == vgat_pkg::V_LAST) ? 10'h000
                                                  : next_vcnt + 10'h001;
    end
    else
    begin
      ahead_col = next_hcnt + 10'h001;
      ahead_row = next_vcnt;
    end
    next_visible = (next_hcnt < vgat_pkg::H_VIS_END) &&
                   (next_vcnt < vgat_pkg::V_VIS_END);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div <= 2'h0;
      hcnt <= 10'h000;
      vcnt <= 10'h000;
    end
    else
    begin
      div <= next_div;
      hcnt <= next_hcnt;
      vcnt <= next_vcnt;
    end
  end

  // Pixel buffer next values
  always_comb
  begin
    push = i_pix_valid && o_pix_ready;
    pop = tick && next_visible && ((fill != 2'h0) || push);
    next_slot = slot;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    if (push)
    begin
      next_slot[wr_idx] = i_pix_data;
      next_wr_idx = ~wr_idx;
    end
    if (pop)
    begin
      next_rd_idx = ~rd_idx;
    end
    case ({push, pop})
      2'b10: next_fill = fill + 2'h1;
      2'b01: next_fill = fill - 2'h1;
      default: next_fill = fill;
    endcase
    next_pix_ready = (next_fill != vgat_pkg::BUF_DEPTH);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      slot[0] <= vgat_pkg::COLOUR_BLANK;
      slot[1] <= vgat_pkg::COLOUR_BLANK;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      fill <= 2'h0;
      o_pix_ready <= 1'b1;
    end
    else
    begin
      slot <= next_slot;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      fill <= next_fill;
      o_pix_ready <= next_pix_ready;
    end
  end

  // Output next values
  always_comb
  begin
    next_fetch.valid = tick && (ahead_col < vgat_pkg::H_VIS_END) &&
                       (ahead_row < vgat_pkg::V_VIS_END);
    next_fetch.pos.col = ahead_col;
    next_fetch.pos.row = ahead_row;
    next_hsync_n = !((next_hcnt >= vgat_pkg::H_SYNC_START) &&
                     (next_hcnt < vgat_pkg::H_SYNC_END));
    next_vsync_n = !((next_vcnt >= vgat_pkg::V_SYNC_START) &&
                     (next_vcnt < vgat_pkg::V_SYNC_END));
    next_colour = o_colour;
    if (pop)
    begin
      if (fill == 2'h0)
      begin
        next_colour = i_pix_data;
      end
      else
      begin
        next_colour = slot[rd_idx];
      end
    end
    else if (tick)
    begin
      next_colour = vgat_pkg::COLOUR_BLANK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_fetch <= '0;
      o_hsync_n <= 1'b1;
      o_vsync_n <= 1'b1;
      o_colour <= vgat_pkg::COLOUR_BLANK;
      o_pos <= '0;
    end
    else
    begin
      o_fetch <= next_fetch;
      o_hsync_n <= next_hsync_n;
      o_vsync_n <= next_vsync_n;
      o_colour <= next_colour;
      o_pos.col <= next_hcnt;
      o_pos.row <= next_vcnt;
    end
  end

  // Checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  pix_rate_a: assert property (tick |=> !tick ##1 tick)
    else $error("pixel tick not every second clock");

  line_wrap_a: assert property
    (tick && hcnt == vgat_pkg::H_LAST |=> hcnt == 10'h000)
    else $error("line did not wrap after 800 pixels");

  frame_wrap_a: assert property
    (tick && hcnt == vgat_pkg::H_LAST && vcnt == vgat_pkg::V_LAST
      |=> vcnt == 10'h000)
    else $error("frame did not wrap after 521 lines");

  col_step_a: assert property
    (tick && hcnt != vgat_pkg::H_LAST |=> hcnt == $past(hcnt) + 10'h001)
    else $error("column counter did not step");

  row_step_a: assert property
    (!(tick && hcnt == vgat_pkg::H_LAST) |=> vcnt == $past(vcnt))
    else $error("row counter moved inside a line");

  hsync_place_a: assert property
    (o_hsync_n == !(o_pos.col >= vgat_pkg::H_SYNC_START &&
                    o_pos.col < vgat_pkg::H_SYNC_END))
    else $error("horizontal sync out of place");

  hsync_start_a: assert property
    ($fell(o_hsync_n) |-> o_pos.col == vgat_pkg::H_SYNC_START)
    else $error("horizontal front porch not 16 pixels");

  hsync_end_a: assert property
    ($rose(o_hsync_n) |-> o_pos.col == vgat_pkg::H_SYNC_END)
    else $error("horizontal sync not 96 pixels");

  vsync_place_a: assert property
    (o_vsync_n == !(o_pos.row >= vgat_pkg::V_SYNC_START &&
                    o_pos.row < vgat_pkg::V_SYNC_END))
    else $error("vertical sync out of place");

  vsync_edges_a: assert property
    ($fell(o_vsync_n) |-> o_pos.row == vgat_pkg::V_SYNC_START &&
                          o_pos.col == 10'h000)
    else $error("vertical front porch not 10 lines");

  colour_blank_a: assert property
    (!(o_pos.col < vgat_pkg::H_VIS_END && o_pos.row < vgat_pkg::V_VIS_END)
      |-> o_colour == vgat_pkg::COLOUR_BLANK)
    else $error("colour driven outside visible area");

  fetch_ahead_a: assert property
    (o_fetch.valid |-> ##2 o_pos == $past(o_fetch.pos, 2))
    else $error("fetched pixel not shown in following period");

  pos_match_a: assert property
    (o_pos.col == hcnt && o_pos.row == vcnt)
    else $error("position output differs from counters");

endmodule : vgat_timing

// *** rtl/vgat_pkg.sv ***
// Constants and types for the 640 by 480 raster timing generator
package vgat_pkg;

  // Clock rates
  localparam int MCLK_HZ = 50_000_000;
  localparam int PIX_HZ = 25_000_000;
  localparam int CLK_PER_PIX = MCLK_HZ / PIX_HZ;
  localparam logic [1:0] DIV_LAST = 2'(CLK_PER_PIX - 1);

  // Counter width
  localparam int CNT_W = 10;

  // Horizontal timing in pixel clocks
  localparam int H_VIS = 640;
  localparam int H_FP = 16;
  localparam int H_PW = 96;
  localparam int H_BP = 48;
  localparam int H_TOTAL = H_VIS + H_FP + H_PW + H_BP;
  localparam logic [9:0] H_VIS_END = 10'(H_VIS);
  localparam logic [9:0] H_SYNC_START = 10'(H_VIS + H_FP);
  localparam logic [9:0] H_SYNC_END = 10'(H_VIS + H_FP + H_PW);
  localparam logic [9:0] H_LAST = 10'(H_TOTAL - 1);

  // Vertical timing in lines
  localparam int V_VIS = 480;
  localparam int V_FP = 10;
  localparam int V_PW = 2;
  localparam int V_BP = 29;
  localparam int V_TOTAL = V_VIS + V_FP + V_PW + V_BP;
  localparam logic [9:0] V_VIS_END = 10'(V_VIS);
  localparam logic [9:0] V_SYNC_START = 10'(V_VIS + V_FP);
  localparam logic [9:0] V_SYNC_END = 10'(V_VIS + V_FP + V_PW);
  localparam logic [9:0] V_LAST = 10'(V_TOTAL - 1);

  // Pixel buffer depth
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // Colour word: eight red, eight green, four blue levels
  typedef struct packed {
    logic [2:0] red;
    logic [2:0] green;
    logic [1:0] blue;
  } vgat_colour_t;

  localparam vgat_colour_t COLOUR_BLANK = 8'h00;

  // Raster position
  typedef struct packed {
    logic [9:0] col;
    logic [9:0] row;
  } vgat_pos_t;

  // Video memory read request
  typedef struct packed {
    logic valid;
    vgat_pos_t pos;
  } vgat_fetch_t;

endpackage : vgat_pkg

// *** sim/vgat_mem_model.sv ***
// Video memory model answering raster fetches over valid/ready
module vgat_mem_model
(
  // Clock, reset and request
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire vgat_pkg::vgat_fetch_t i_fetch,
  // Pixel return stream
  input wire logic i_ready,
  output logic o_valid,
  output vgat_pkg::vgat_colour_t o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  vgat_pkg::vgat_colour_t fifo[$];
  initial
  begin
    o_valid = 1'b0;
    o_data = 8'hFF;
  end
  always @(posedge i_mclk)
  begin
    if (!i_reset_n)
      fifo.delete();
    else if (o_valid && i_ready)
      void'(fifo.pop_front());
    if (i_reset_n && i_fetch.valid)
      fifo.push_back(i_fetch.pos.col[7:0] ^ i_fetch.pos.row[7:0]);
    #1;
    o_valid = (fifo.size() != 0);
    o_data = o_valid ? fifo[0] : ~o_data;
  end
endmodule : vgat_mem_model

// *** sim/testbench.sv ***
// Self-checking bench for the raster timing generator
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [9:0] c; logic [9:0] r; logic hs; logic vs;}
    vgat_row_t;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic pix_valid;
  logic pix_ready;
  logic o_hsync_n;
  logic o_vsync_n;
  vgat_pkg::vgat_colour_t pix_data;
  vgat_pkg::vgat_colour_t o_colour;
  vgat_pkg::vgat_pos_t o_pos;
  vgat_pkg::vgat_pos_t last;
  vgat_pkg::vgat_fetch_t fetch;
  int error_cnt = 0;
  int tests_run = 0;
  int hold = -1;
  vgat_row_t rows[17] = '{
    '{10'h005, 10'h000, 1'b1, 1'b1}, '{10'h27F, 10'h000, 1'b1, 1'b1},
    '{10'h280, 10'h000, 1'b1, 1'b1}, '{10'h28F, 10'h000, 1'b1, 1'b1},
    '{10'h290, 10'h000, 1'b0, 1'b1}, '{10'h2EF, 10'h000, 1'b0, 1'b1},
    '{10'h2F0, 10'h000, 1'b1, 1'b1}, '{10'h31F, 10'h000, 1'b1, 1'b1},
    '{10'h000, 10'h001, 1'b1, 1'b1}, '{10'h003, 10'h1DF, 1'b1, 1'b1},
    '{10'h003, 10'h1E0, 1'b1, 1'b1}, '{10'h003, 10'h1E9, 1'b1, 1'b1},
    '{10'h003, 10'h1EA, 1'b1, 1'b0}, '{10'h2BC, 10'h1EB, 1'b0, 1'b0},
    '{10'h003, 10'h1EC, 1'b1, 1'b1}, '{10'h31F, 10'h208, 1'b1, 1'b1},
    '{10'h000, 10'h000, 1'b1, 1'b1}};

  always #10 i_mclk = ~i_mclk;

  vgat_timing i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .o_fetch(fetch), .i_pix_valid(pix_valid), .i_pix_data(pix_data),
    .o_pix_ready(pix_ready), .o_hsync_n(o_hsync_n),
    .o_vsync_n(o_vsync_n), .o_colour(o_colour), .o_pos(o_pos));

  vgat_mem_model i_mem (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_fetch(fetch), .i_ready(pix_ready), .o_valid(pix_valid),
    .o_data(pix_data));

  function automatic vgat_pkg::vgat_pos_t succ(vgat_pkg::vgat_pos_t p);
    succ.col = (p.col == 10'h31F) ? 10'h000 : p.col + 10'h001;
    succ.row = (p.col != 10'h31F) ? p.row :
      (p.row == 10'h208) ? 10'h000 : p.row + 10'h001;
  endfunction : succ

  function automatic logic vis(vgat_pkg::vgat_pos_t p);
    return (p.col < 10'h280) && (p.row < 10'h1E0);
  endfunction : vis

  task automatic chk_val(string n, logic [19:0] e, logic [19:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string n, logic e, logic g);
    chk_val(n, 20'(e), 20'(g));
  endtask : chk_bit

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic wait_pos(vgat_pkg::vgat_pos_t p);
    int n;
    n = 0;
    while (o_pos !== p)
    begin
      @(negedge i_mclk);
      n++;
      if (n > 900000)
      begin
        error_cnt++;
        print_verdict();
      end
    end
  endtask : wait_pos

  // Raster continuity and fetch timing
  always @(negedge i_mclk)
  begin
    if (!i_reset_n)
      hold = -1;
    else if (o_pos === last)
    begin
      hold++;
      chk_bit("idle fetch", 1'b0, fetch.valid);
    end
    else
    begin
      chk_val("pos step", 20'(succ(last)), 20'(o_pos));
      chk_val("pix hold", 20'h00001, 20'(hold));
      chk_bit("fetch", vis(succ(o_pos)), fetch.valid);
      chk_bit("pix ready", 1'b1, pix_ready);
      if (fetch.valid === 1'b1)
        chk_val("fetch pos", 20'(succ(o_pos)), 20'(fetch.pos));
      hold = 0;
    end
    last = o_pos;
  end

  initial
  begin
    vgat_pkg::vgat_pos_t p;
    logic [19:0] e;
    repeat (8) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    foreach (rows[i])
    begin
      p.col = rows[i].c;
      p.row = rows[i].r;
      e = vis(p) ? 20'(p.col[7:0] ^ p.row[7:0]) : 20'h00000;
      wait_pos(p);
      chk_bit("hsync", rows[i].hs, o_hsync_n);
      chk_bit("vsync", rows[i].vs, o_vsync_n);
      chk_val("colour", e, 20'(o_colour));
    end
    @(posedge i_mclk);
    #1 i_reset_n = 1'b0;
    #5;
    chk_val("rst pos", 20'h00000, 20'(o_pos));
    chk_val("rst colour", 20'h00000, 20'(o_colour));
    chk_bit("rst hsync", 1'b1, o_hsync_n);
    chk_bit("rst vsync", 1'b1, o_vsync_n);
    chk_bit("rst ready", 1'b1, pix_ready);
    repeat (3) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 chk_val("first step", 20'h00400, 20'(o_pos));
    repeat (2) @(posedge i_mclk);
    #1 chk_val("first colour", 20'h00002, 20'(o_colour));
    print_verdict();
  end
endmodule : testbench
